// >>> ohnp_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "ohnp_defines.svh"
// Behaviour
// - As A-device, partner role swap requests are honoured only when host enable is set.
// - Host enable bit is writable by software only in host mode.
// - Writing one to request bit starts role swap; only in device mode.
// - After end flag sets, request clears by writing zero or clearing end flag.
// - Success bit set on success, cleared whenever request bit is set.
module ohnp_control (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire ohnp_pkg::ohnp_addr_type i_addr,
  input wire ohnp_pkg::ohnp_data_type i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output var ohnp_pkg::ohnp_data_type o_rdata,
  input wire logic i_host_mode,
  input wire logic i_partner_swap_req,
  input wire logic i_swap_done,
  input wire logic i_swap_ok,
  output logic o_start_swap,
  output logic o_accept_partner_swap,
  output logic o_irq
);
  import ohnp_pkg::*;

  // ==========================================
  // State
  logic host_role_swap_enable;
  logic role_swap_request;
  logic role_swap_success;
  logic [`OHNP_INT_WIDTH-1:0] int_flag;
  logic [`OHNP_INT_WIDTH-1:0] int_mask;
  ohnp_data_type next_rdata;

  // ==========================================
  // Decode
  wire wr_ctrl = i_wr && (i_addr == `OHNP_CTRL_ADDR);
  wire wr_flag = i_wr && (i_addr == `OHNP_INT_FLAG_ADDR);
  wire wr_mask = i_wr && (i_addr == `OHNP_INT_MASK_ADDR);
  wire wr_host_en = wr_ctrl && i_host_mode;
  wire wr_req = wr_ctrl && !i_host_mode;
  wire role_swap_end_flag = int_flag[`OHNP_END_FLAG_BIT];
  wire end_flag_cleared = wr_flag && i_wdata[`OHNP_END_FLAG_BIT] && !i_swap_done;
  wire req_set = wr_req && i_wdata[`OHNP_REQUEST_BIT];
  wire req_clr = role_swap_end_flag && ((wr_req && !i_wdata[`OHNP_REQUEST_BIT]) || end_flag_cleared);
  wire partner_ok = i_host_mode && host_role_swap_enable && i_partner_swap_req;
  wire [`OHNP_INT_WIDTH-1:0] ev = {partner_ok, i_swap_done && role_swap_request};
  wire [`OHNP_INT_WIDTH-1:0] clr = wr_flag ? i_wdata[`OHNP_INT_WIDTH-1:0] : '0;

  // Outputs to the link side, and the interrupt line
  assign o_start_swap = role_swap_request && !i_host_mode;
  assign o_accept_partner_swap = partner_ok;
  assign o_irq = |(int_flag & int_mask);

  // Read mux; success bit only ever read
  always_comb begin
    next_rdata = '0;
    if (i_addr == `OHNP_CTRL_ADDR) begin
      next_rdata[`OHNP_HOST_EN_BIT] = host_role_swap_enable;
      next_rdata[`OHNP_REQUEST_BIT] = role_swap_request;
      next_rdata[`OHNP_SUCCESS_BIT] = role_swap_success;
    end else if (i_addr == `OHNP_INT_FLAG_ADDR) begin
      next_rdata[`OHNP_INT_WIDTH-1:0] = int_flag;
    end else if (i_addr == `OHNP_INT_MASK_ADDR) begin
      next_rdata[`OHNP_INT_WIDTH-1:0] = int_mask;
    end
  end

  // Control bits
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      host_role_swap_enable <= 1'b0;
      role_swap_request <= 1'b0;
      role_swap_success <= 1'b0;
    end else begin
      if (wr_host_en) begin
        host_role_swap_enable <= i_wdata[`OHNP_HOST_EN_BIT];
      end
      if (req_set) begin
        role_swap_request <= 1'b1;
      end else if (req_clr) begin
        role_swap_request <= 1'b0;
      end
      if (req_set) begin
        role_swap_success <= 1'b0;
      end else if (i_swap_done && role_swap_request) begin
        role_swap_success <= i_swap_ok;
      end
    end
  end

  // Sticky flags (set beats clear), mask, read data
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      int_flag <= '0;
      int_mask <= `OHNP_INT_MASK_RESET;
      o_rdata <= '0;
    end else begin
      int_flag <= (int_flag & ~clr) | ev;
      if (wr_mask) begin
        int_mask <= i_wdata[`OHNP_INT_WIDTH-1:0];
      end
      o_rdata <= i_rd ? next_rdata : '0;
    end
  end

  // ==========================================
  // Assertions
  // Host enable frozen outside host mode
  a_host_en_guard: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_host_mode == 1'b0 |=> $stable(host_role_swap_enable))
    else $error("host enable changed outside host mode");

  // Host enable follows a host mode write of one
  a_host_en_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_wr && i_addr == `OHNP_CTRL_ADDR && i_host_mode && i_wdata[`OHNP_HOST_EN_BIT]) |=> host_role_swap_enable)
    else $error("host enable not set by write");

  // Host enable follows a host mode write of zero
  a_host_en_clr: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_wr && i_addr == `OHNP_CTRL_ADDR && i_host_mode && !i_wdata[`OHNP_HOST_EN_BIT]) |=> !host_role_swap_enable)
    else $error("host enable not cleared by write");

  // Partner requests only honoured while enabled
  a_accept_gated: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_accept_partner_swap |-> (host_role_swap_enable && i_partner_swap_req && i_host_mode))
    else $error("partner request honoured while disabled");

  // Clearing the enable stops honouring partner requests
  a_accept_off: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_wr && i_addr == `OHNP_CTRL_ADDR && i_host_mode && !i_wdata[`OHNP_HOST_EN_BIT]) |=> !o_accept_partner_swap)
    else $error("partner request honoured after disable");

  // An honoured partner request is recorded as a flag
  a_partner_flag: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_accept_partner_swap |=> int_flag[`OHNP_PARTNER_REQ_FLAG_BIT])
    else $error("honoured request left no flag");

  // Device mode write of one raises the request
  a_req_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_wr && i_addr == `OHNP_CTRL_ADDR && !i_host_mode && i_wdata[`OHNP_REQUEST_BIT]) |=> role_swap_request)
    else $error("request not set by write");

  // Request cannot be raised in host mode
  a_req_refused: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_host_mode && !role_swap_request) |=> !role_swap_request)
    else $error("request raised in host mode");

  // Request holds until the end flag is up
  a_req_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (role_swap_request && !role_swap_end_flag) |=> role_swap_request)
    else $error("request cleared before end flag");

  // Writing zero after the end flag drops the request
  a_req_clr_zero: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_wr && i_addr == `OHNP_CTRL_ADDR && !i_host_mode && !i_wdata[`OHNP_REQUEST_BIT] && role_swap_end_flag)
      |=> !role_swap_request)
    else $error("request not cleared by zero write");

  // Clearing the end flag drops the request
  a_req_clr_flag: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_wr && i_addr == `OHNP_INT_FLAG_ADDR && i_wdata[`OHNP_END_FLAG_BIT] && role_swap_end_flag && !i_swap_done)
      |=> !role_swap_request)
    else $error("request not cleared with end flag");

  // Success cleared as the request rises
  a_success_clr: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $rose(role_swap_request) |-> !role_swap_success)
    else $error("success not cleared on request");

  // Success takes the outcome at the end of a swap
  a_success_take: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_swap_done && role_swap_request && !req_set) |=> (role_swap_success == $past(i_swap_ok)))
    else $error("success does not match outcome");

  // Success changes only at a swap end or on a control register write
  a_success_ro: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (!i_swap_done && !(i_wr && i_addr == `OHNP_CTRL_ADDR)) |=> $stable(role_swap_success))
    else $error("success bit changed without cause");

  // Start only offered in device mode
  a_start_mode: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_start_swap |-> (!i_host_mode && role_swap_request))
    else $error("swap started in host mode");

  // End event always lands in the flag
  a_end_set_wins: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_swap_done && role_swap_request) |=> role_swap_end_flag)
    else $error("end event lost");

  // End flag stays until cleared by a one
  a_end_sticky: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (role_swap_end_flag && !(i_wr && i_addr == `OHNP_INT_FLAG_ADDR && i_wdata[`OHNP_END_FLAG_BIT]))
      |=> role_swap_end_flag)
    else $error("end flag dropped by itself");

  // Writing one to the end flag clears it
  a_flag_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_wr && i_addr == `OHNP_INT_FLAG_ADDR && i_wdata[`OHNP_END_FLAG_BIT] && !i_swap_done)
      |=> !role_swap_end_flag)
    else $error("end flag not cleared by write");

  // Unmasked end event raises the interrupt
  a_irq_flag: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_swap_done && role_swap_request && int_mask[`OHNP_END_FLAG_BIT] && !wr_mask) |=> o_irq)
    else $error("end event raised no interrupt");

  // Reset clears every control and flag bit
  a_reset_clear: assert property (@(posedge i_core_clk)
    i_sys_rst |=> (!host_role_swap_enable && !role_swap_request && !role_swap_success && int_flag == '0))
    else $error("state not cleared by reset");

  // Read data idle low between reads
  a_rdata_idle: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !i_rd |=> (o_rdata == '0))
    else $error("read data shown without read");

  // Read back of the success bit
  a_rdata_success: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_rd && i_addr == `OHNP_CTRL_ADDR) |=> (o_rdata[`OHNP_SUCCESS_BIT] == $past(role_swap_success)))
    else $error("success bit read back wrong");

  // Read back of the request bit
  a_rdata_req: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_rd && i_addr == `OHNP_CTRL_ADDR) |=> (o_rdata[`OHNP_REQUEST_BIT] == $past(role_swap_request)))
    else $error("request bit read back wrong");
endmodule
`default_nettype wire

// >>> ohnp_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ohnp_control_tb;
  import ohnp_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, rd_q = 0, host = 0, ask = 0, good = 1;
  ohnp_addr_type addr = '0;
  ohnp_data_type wdata = '0, rdata, exp_q[$];
  logic [31:0] lfsr = 32'h92f7aff7;
  int miscompares = 0, total_checks = 0;
  wire start, accept, irq, preq, done, ok;
  ohnp_control uut (.i_core_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_host_mode(host), .i_partner_swap_req(preq), .i_swap_done(done),
    .i_swap_ok(ok), .o_start_swap(start), .o_accept_partner_swap(accept), .o_irq(irq));
  ohnp_partner far (.i_clk(clk), .i_start(start), .i_ask(ask), .i_good(good), .o_preq(preq), .o_done(done),
    .o_ok(ok));
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Next value of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // One bus cycle; a read notes its expected word
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    if (!w) exp_q.push_back(d);
    @(posedge clk);
    wr <= 0;
    rd <= 0;
  endtask
  // Read data watcher
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) if (rd_q) chk(rdata, exp_q.pop_front());
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #150000;
    miscompares++;
    give_verdict;
  end
  // =====
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    acc(0, 0, 0);
    acc(1, 0, 32'h700);
    acc(0, 0, 32'h200);
    @(negedge clk) chk(start, 1);
    acc(1, 2, 1);
    repeat (6) @(posedge clk);
    acc(0, 0, 32'h300);
    @(negedge clk) chk(irq, 1);
    acc(1, 1, 1);
    acc(0, 0, 32'h100);
    @(negedge clk) chk(irq, 0);
    good <= 1'b0;
    acc(1, 0, 32'h200);
    acc(0, 0, 32'h200);
    repeat (6) @(posedge clk);
    acc(0, 0, 32'h200);
    acc(1, 0, 0);
    acc(0, 0, 0);
    @(negedge clk) chk(start, 0);
    acc(1, 1, 1);
    host <= 1;
    ask <= 1;
    acc(1, 0, 32'h600);
    acc(0, 0, 32'h400);
    @(negedge clk) chk(accept, 1);
    acc(1, 1, 2);
    acc(0, 1, 2);
    acc(1, 0, 0);
    @(negedge clk) chk(accept, 0);
    repeat (2) begin
      lfsr = lfsr_next(lfsr);
      acc(1, 4'h2, lfsr);
      acc(0, 4'h2, {30'h0, lfsr[1:0]});
      @(negedge clk) chk(irq, lfsr[1]);
      acc(1, 4'h3, lfsr);
      acc(0, 4'h3, 0);
    end
    // Reset in mid-run clears everything
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    acc(0, 0, 0);
    acc(0, 1, 0);
    @(negedge clk) chk(irq, 0);
    chk(accept, 0);
    repeat (2) @(posedge clk);
    if (exp_q.size() != 0) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, exp_q.size(), 0);
    end
    give_verdict;
  end
endmodule
`default_nettype wire

// >>> ohnp_defines.svh
`ifndef OHNP_DEFINES_SVH
`define OHNP_DEFINES_SVH
// ==========================================
// Register map
`define OHNP_CTRL_ADDR 4'h0
`define OHNP_INT_FLAG_ADDR 4'h1
`define OHNP_INT_MASK_ADDR 4'h2
// ==========================================
// Control register fields
`define OHNP_SUCCESS_BIT 8
`define OHNP_REQUEST_BIT 9
`define OHNP_HOST_EN_BIT 10
// ==========================================
// Interrupt flag fields
`define OHNP_END_FLAG_BIT 0
`define OHNP_PARTNER_REQ_FLAG_BIT 1
`define OHNP_INT_WIDTH 2
`define OHNP_INT_MASK_RESET 2'h0
`endif

// >>> ohnp_partner.sv
`timescale 1ns/10ps
`default_nettype none
// =====
// Far-side partner model
module ohnp_partner #(parameter int DELAY = 3) (
  input wire logic i_clk,
  input wire logic i_start,
  input wire logic i_ask,
  input wire logic i_good,
  output logic o_preq,
  output logic o_done,
  output logic o_ok
);
  int cnt = 0;
  logic seen = 1'b0;
  // Answers each new swap start with a late done pulse
  always @(posedge i_clk) begin
    seen <= i_start;
    o_done <= (cnt == 1);
    if (i_start && !seen) cnt <= DELAY;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign o_ok = o_done && i_good; // Outcome given beside done
  assign o_preq = i_ask; // Swap request from the far side
endmodule
`default_nettype wire

// >>> ohnp_pkg.sv
`default_nettype none
package ohnp_pkg;
  typedef logic [3:0] ohnp_addr_type;
  typedef logic [31:0] ohnp_data_type;
endpackage
`default_nettype wire
